// ===== rsq_pkg.sv
// Shared constants and types of the display hardware-reset sequencer
package rsq_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned US_PER_MS      = 1000;
    // Pulse widths on the reset pin, in microseconds
    localparam int unsigned GLITCH_US      = 5;
    localparam int unsigned RESET_SURE_US  = 9;
    // Completion and blanking times, in milliseconds
    localparam int unsigned RT_SLPIN_MS    = 5;
    localparam int unsigned RT_SLPOUT_MS   = 120;
    localparam int unsigned BLANK_MS       = 120;
    // Derived cycle counts (all exact at 125 MHz)
    localparam int unsigned GLITCH_CYC     = GLITCH_US * CLK_MHZ;
    localparam int unsigned RESET_SURE_CYC = RESET_SURE_US * CLK_MHZ;
    localparam int unsigned RT_SLPIN_CYC   = RT_SLPIN_MS * US_PER_MS * CLK_MHZ;
    localparam int unsigned RT_SLPOUT_CYC  = RT_SLPOUT_MS * US_PER_MS * CLK_MHZ;
    localparam int unsigned BLANK_CYC      = BLANK_MS * US_PER_MS * CLK_MHZ;
    // Counter, byte and command widths, and layout of the stored settings
    localparam int unsigned RUN_W          = 16;
    localparam int unsigned TMR_W          = 24;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned CMD_W          = 9;
    localparam int unsigned NVM_WORDS      = 8;
    localparam int unsigned NVM_ID_WORDS   = 3;
    localparam int unsigned NVM_COMMON_VOLTAGE_SETTING_IDX   = 3;

    typedef enum logic [1:0] {
        RSQ_LOAD  = 2'b00,
        RSQ_HOLD  = 2'b01,
        RSQ_WAIT  = 2'b10,
        RSQ_READY = 2'b11
    } rsq_seq_st_t;
endpackage : rsq_pkg

// ===== rsq_filt_if.sv
// Filtered reset level and its edge pulses between filter and sequencer
`timescale 1ns/1ns
interface rsq_filt_if;
    logic active;
    logic accept;
    logic rel;
    modport src (output active, output accept, output rel);
    modport dst (input active, input accept, input rel);
endinterface : rsq_filt_if

// ===== rsq_glitch_filter.sv
// Spike filter on the active-low hardware reset pin
`timescale 1ns/1ns
module rsq_glitch_filter #(
    parameter int unsigned REJECT_CYC = rsq_pkg::GLITCH_CYC
) (
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire logic hw_reset_n_i,
    rsq_filt_if.src   flt
);
    typedef logic [rsq_pkg::RUN_W-1:0] rsq_run_t;
    typedef struct packed {
        logic     active;
        logic     accept;
        logic     rel;
        rsq_run_t cnt;
    } rsq_flt_state_t;

    localparam rsq_run_t LAST = rsq_run_t'(REJECT_CYC - 1);

    rsq_flt_state_t s_q;
    rsq_flt_state_t s_d;

    always_comb begin
        s_d        = s_q;
        s_d.accept = 1'b0;
        s_d.rel    = 1'b0;
        // Pin disagrees with the filtered level: both directions filtered
        if (hw_reset_n_i == s_q.active) begin
            if (s_q.cnt == LAST) begin
                s_d.active = !s_q.active;
                s_d.accept = !s_q.active;
                s_d.rel    = s_q.active;
                s_d.cnt    = '0;
            end else begin
                s_d.cnt = rsq_run_t'(s_q.cnt + 1'b1);
            end
        end else begin
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flt.active = s_q.active;
    assign flt.accept = s_q.accept;
    assign flt.rel    = s_q.rel;

    // Run lengths of the raw pin, seen only by the checks below
    int unsigned lo_run;
    int unsigned hi_run;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lo_run <= 0;
            hi_run <= 0;
        end else begin
            lo_run <= hw_reset_n_i ? 0 : lo_run + 1;
            hi_run <= hw_reset_n_i ? hi_run + 1 : 0;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    accept_width_a: assert property (
        $rose(s_q.active) |-> lo_run >= REJECT_CYC)
        else $error("reset accepted after a too short low pulse");
    long_pulse_a: assert property (
        lo_run >= rsq_pkg::RESET_SURE_CYC |-> s_q.active)
        else $error("long low pulse not taken as reset");
    spike_hold_a: assert property (
        $fell(s_q.active) |-> hi_run >= REJECT_CYC)
        else $error("reset dropped by a short high spike");
    edge_pulse_a: assert property (
        s_q.accept == $rose(s_q.active))
        else $error("accept pulse not tied to reset edge");

    accept_c: cover property (s_q.accept);
    spike_c:  cover property ($rose(hw_reset_n_i) && !s_q.active
                              && lo_run > 0);
endmodule : rsq_glitch_filter

// ===== rsq_display_hw_reset_sequencer.sv
// Hardware reset sequencer: filter, blanking, settings reload, ready
`timescale 1ns/1ns
module rsq_display_hw_reset_sequencer #(
    parameter int unsigned RT_IN_CYC  = rsq_pkg::RT_SLPIN_CYC,
    parameter int unsigned RT_OUT_CYC = rsq_pkg::RT_SLPOUT_CYC,
    parameter int unsigned BLANK_CYC  = rsq_pkg::BLANK_CYC,
    parameter int unsigned REJECT_CYC = rsq_pkg::GLITCH_CYC,
    parameter int unsigned NVM_WORDS  = rsq_pkg::NVM_WORDS,
    parameter int unsigned CMD_W      = rsq_pkg::CMD_W,
    parameter int unsigned TMR_W      = rsq_pkg::TMR_W
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rstn_i,
    input  wire logic                          hw_reset_n_i,
    input  wire logic                          sleep_in_i,
    input  wire logic [rsq_pkg::BYTE_W-1:0]    nvm_rdata_i,
    input  wire logic                          cmd_valid_i,
    input  wire logic [CMD_W-1:0]              cmd_data_i,
    output logic                               nvm_rd_o,
    output logic [$clog2(NVM_WORDS)-1:0]       nvm_addr_o,
    output logic [NVM_WORDS*rsq_pkg::BYTE_W-1:0] settings_o,
    output logic [rsq_pkg::NVM_ID_WORDS*rsq_pkg::BYTE_W-1:0] id_o,
    output logic [rsq_pkg::BYTE_W-1:0]         common_voltage_setting_o,
    output logic                               blank_o,
    output logic                               blank_seq_o,
    output logic                               ready_o,
    output logic                               dflt_load_o,
    output logic                               cmd_valid_o,
    output logic [CMD_W-1:0]                   cmd_data_o,
    output logic                               cmd_drop_o
);
    localparam int unsigned AW = $clog2(NVM_WORDS);

    typedef logic [TMR_W-1:0] rsq_tmr_t;
    typedef logic [AW-1:0]    rsq_addr_t;
    typedef struct packed {
        rsq_pkg::rsq_seq_st_t                        state;
        logic                                        awake;
        rsq_tmr_t                                    tmr;
        rsq_tmr_t                                    bcnt;
        logic                                        rd_wait;
        logic [NVM_WORDS-1:0][rsq_pkg::BYTE_W-1:0]   settings;
        logic                                        nvm_rd;
        rsq_addr_t                                   nvm_addr;
        logic                                        blank;
        logic                                        blank_seq;
        logic                                        ready;
        logic                                        dflt;
        logic                                        cmd_v;
        logic [CMD_W-1:0]                            cmd_d;
        logic                                        drop;
    } rsq_seq_state_t;

    localparam rsq_tmr_t  RT_IN_LAST  = rsq_tmr_t'(RT_IN_CYC - 1);
    localparam rsq_tmr_t  RT_OUT_LAST = rsq_tmr_t'(RT_OUT_CYC - 1);
    localparam rsq_tmr_t  BLANK_LAST  = rsq_tmr_t'(BLANK_CYC - 1);
    localparam rsq_addr_t ADDR_LAST   = rsq_addr_t'(NVM_WORDS - 1);
    // Release filter delay counts against the completion bound
    localparam rsq_tmr_t  REL_TMR     = rsq_tmr_t'(REJECT_CYC + 1);

    rsq_filt_if     fl ();
    rsq_seq_state_t s_q;
    rsq_seq_state_t s_d;
    logic           is_ready;
    rsq_tmr_t       rt_last;

    rsq_glitch_filter #(
        .REJECT_CYC   (REJECT_CYC)
    ) u_filter (
        .sys_clk_i    (sys_clk_i),
        .rstn_i       (rstn_i),
        .hw_reset_n_i (hw_reset_n_i),
        .flt          (fl)
    );

    always_comb begin
        is_ready  = (s_q.state == rsq_pkg::RSQ_READY);
        // Completion bound depends on the sleep mode caught at reset entry
        rt_last   = s_q.awake ? RT_OUT_LAST : RT_IN_LAST;
        s_d       = s_q;
        s_d.dflt  = 1'b0;
        s_d.nvm_rd = 1'b0;
        s_d.cmd_v = cmd_valid_i && is_ready;
        s_d.drop  = cmd_valid_i && !is_ready;
        if (cmd_valid_i && is_ready) begin
            s_d.cmd_d = cmd_data_i;
        end
        // Blanking sequence runs on its own count, also past release
        if (s_q.blank_seq) begin
            if (s_q.bcnt == BLANK_LAST) begin
                s_d.blank_seq = 1'b0;
            end else begin
                s_d.bcnt = rsq_tmr_t'(s_q.bcnt + 1'b1);
            end
        end
        if (fl.accept) begin
            s_d.state     = rsq_pkg::RSQ_HOLD;
            s_d.blank     = 1'b1;
            s_d.ready     = 1'b0;
            s_d.awake     = !sleep_in_i;
            s_d.blank_seq = !sleep_in_i;
            s_d.bcnt      = '0;
            s_d.rd_wait   = 1'b0;
        end else begin
            unique case (s_q.state)
                rsq_pkg::RSQ_HOLD: begin
                    if (fl.rel) begin
                        s_d.state    = rsq_pkg::RSQ_LOAD;
                        // Bound runs from the pin edge, not the filter
                        s_d.tmr      = REL_TMR;
                        s_d.nvm_addr = '0;
                        s_d.rd_wait  = 1'b0;
                    end
                end
                rsq_pkg::RSQ_LOAD: begin
                    s_d.blank = 1'b1;
                    s_d.tmr   = rsq_tmr_t'(s_q.tmr + 1'b1);
                    if (!s_q.rd_wait) begin
                        s_d.nvm_rd  = 1'b1;
                        s_d.rd_wait = 1'b1;
                    end else if (!s_q.nvm_rd) begin
                        // Data stands one cycle after the read strobe
                        s_d.settings[s_q.nvm_addr] = nvm_rdata_i;
                        s_d.rd_wait = 1'b0;
                        if (s_q.nvm_addr == ADDR_LAST) begin
                            s_d.state = rsq_pkg::RSQ_WAIT;
                        end else begin
                            s_d.nvm_addr = rsq_addr_t'(s_q.nvm_addr + 1'b1);
                        end
                    end
                end
                rsq_pkg::RSQ_WAIT: begin
                    s_d.tmr = rsq_tmr_t'(s_q.tmr + 1'b1);
                    // Shortened counts may end before the reload does
                    if (s_q.tmr >= rt_last) begin
                        s_d.state = rsq_pkg::RSQ_READY;
                        s_d.ready = 1'b1;
                        s_d.blank = 1'b0;
                        s_d.dflt  = 1'b1;
                    end
                end
                rsq_pkg::RSQ_READY: begin
                end
            endcase
        end
    end

    // All-zero reset doubles as power-on: reload from sleep-in
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign nvm_rd_o     = s_q.nvm_rd;
    assign nvm_addr_o   = s_q.nvm_addr;
    assign settings_o   = s_q.settings;
    assign id_o         = s_q.settings[rsq_pkg::NVM_ID_WORDS-1:0];
    assign common_voltage_setting_o = s_q.settings[rsq_pkg::NVM_COMMON_VOLTAGE_SETTING_IDX];
    assign blank_o      = s_q.blank;
    assign blank_seq_o  = s_q.blank_seq;
    assign ready_o      = s_q.ready;
    assign dflt_load_o  = s_q.dflt;
    assign cmd_valid_o  = s_q.cmd_v;
    assign cmd_data_o   = s_q.cmd_d;
    assign cmd_drop_o   = s_q.drop;

    // Cycles since the pin was last seen low, seen only by the checks
    // Taken from the raw pin so the filter delay is included
    int unsigned rel_cnt;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rel_cnt <= 0;
        end else begin
            rel_cnt <= hw_reset_n_i ? rel_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    reload_start_a: assert property (
        fl.rel |=> s_q.state == rsq_pkg::RSQ_LOAD && s_q.nvm_addr == '0)
        else $error("release did not start the settings reload");
    reload_done_a: assert property (
        $rose(ready_o) |-> $past(s_q.state) == rsq_pkg::RSQ_WAIT)
        else $error("ready without finished reload");
    complete_time_a: assert property (
        $rose(ready_o) |-> rel_cnt <= (s_q.awake ? RT_OUT_CYC : RT_IN_CYC))
        else $error("reset completion took too long");
    blank_reset_a: assert property (
        fl.active |=> blank_o && !ready_o)
        else $error("display not blanked during reset");
    blank_seq_a: assert property (
        blank_seq_o |-> s_q.awake && s_q.bcnt <= BLANK_LAST)
        else $error("blanking sequence wrong mode or too long");
    default_pulse_a: assert property (
        $rose(ready_o) |-> dflt_load_o ##1 !dflt_load_o)
        else $error("default load pulse missing at completion");
    cmd_drop_a: assert property (
        cmd_valid_i && !ready_o |=> cmd_drop_o && !cmd_valid_o)
        else $error("command taken while reset completes");
    cmd_pass_a: assert property (
        cmd_valid_i && ready_o |=> cmd_valid_o
        && cmd_data_o == $past(cmd_data_i))
        else $error("command lost while ready");

    ready_out_c: cover property (s_q.awake && $rose(ready_o));
    ready_in_c:  cover property (!s_q.awake && $rose(ready_o) && rel_cnt > 0);
    drop_c:      cover property (cmd_drop_o);
endmodule : rsq_display_hw_reset_sequencer

// ===== rsq_host_model.sv
// Host controller model: drives the reset pin and the command strobe
`timescale 1ns/1ns
module rsq_host_model #(
    parameter int unsigned WAIT_CYC = 200
) (
    input  wire logic                      sys_clk_i,
    output logic                           hw_reset_n_o,
    output logic                           cmd_valid_o,
    output logic [rsq_pkg::CMD_W-1:0]      cmd_data_o
);
    int unsigned since_rel = 0;

    initial begin
        hw_reset_n_o = 1'b1;
        cmd_valid_o  = 1'b0;
        cmd_data_o   = 9'h0a5;
    end

    // Cycles since the pin was last released
    always @(posedge sys_clk_i) begin
        since_rel <= hw_reset_n_o ? since_rel + 1 : 0;
    end

    // Caller sits at a falling edge; pin is sampled n times at this level
    task automatic drive_pin(input logic lvl, input int unsigned n);
        hw_reset_n_o = lvl;
        repeat (n) @(negedge sys_clk_i);
    endtask : drive_pin

    // Early sends break the hold-off on purpose to probe discarding
    task automatic send_cmd(input logic [rsq_pkg::CMD_W-1:0] d,
                            input bit early);
        if (!early) begin
            while (since_rel < WAIT_CYC) @(negedge sys_clk_i);
        end
        cmd_valid_o = 1'b1;
        cmd_data_o  = d;
        @(negedge sys_clk_i);
        cmd_valid_o = 1'b0;
        // Idle data shows the inverse so a stale value cannot match
        cmd_data_o  = ~d;
    endtask : send_cmd
endmodule : rsq_host_model

// ===== testbench.sv
// Self-checking testbench of the display hardware-reset sequencer
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module testbench;
    localparam int unsigned REJ    = 10;
    localparam int unsigned RT_IN  = 200;
    localparam int unsigned RT_OUT = 400;
    localparam int unsigned BLANK  = 300;
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        pin_n;
    logic        sleep_in  = 1'b1;
    logic [7:0]  nvm_rdata;
    logic        cmd_v;
    logic [8:0]  cmd_d;
    logic        nvm_rd;
    logic [2:0]  nvm_addr;
    logic [63:0] settings;
    logic [23:0] id;
    logic [7:0]  common_voltage_setting;
    logic        blank;
    logic        blank_seq;
    logic        ready;
    logic        dflt_load;
    logic        cmd_vo;
    logic [8:0]  cmd_do;
    logic        cmd_drop;
    logic [7:0]  nvm_base  = 8'h30;
    logic        rd_d1_q   = 1'b0;
    int          rd_cnt    = 0;
    int          fails     = 0;
    int          n_checks  = 0;

    always #4 clk = ~clk;

    // Stored-settings memory: valid in the strobe cycle and the next
    always @(posedge clk) begin
        rd_d1_q <= nvm_rd;
        if (nvm_rd === 1'b1) rd_cnt++;
    end
    assign nvm_rdata = (nvm_rd || rd_d1_q) ? nvm_base + 8'h11 * nvm_addr
                                           : ~(nvm_base + 8'h11 * nvm_addr);

    rsq_host_model #(.WAIT_CYC(RT_IN)) host (
        .sys_clk_i    (clk),
        .hw_reset_n_o (pin_n),
        .cmd_valid_o  (cmd_v),
        .cmd_data_o   (cmd_d)
    );

    rsq_display_hw_reset_sequencer #(
        .RT_IN_CYC(RT_IN), .RT_OUT_CYC(RT_OUT),
        .BLANK_CYC(BLANK), .REJECT_CYC(REJ)
    ) dut (
        .sys_clk_i                (clk),
        .rstn_i                   (rst_n),
        .hw_reset_n_i             (pin_n),
        .sleep_in_i               (sleep_in),
        .nvm_rdata_i              (nvm_rdata),
        .cmd_valid_i              (cmd_v),
        .cmd_data_i               (cmd_d),
        .nvm_rd_o                 (nvm_rd),
        .nvm_addr_o               (nvm_addr),
        .settings_o               (settings),
        .id_o                     (id),
        .common_voltage_setting_o (common_voltage_setting),
        .blank_o                  (blank),
        .blank_seq_o              (blank_seq),
        .ready_o                  (ready),
        .dflt_load_o              (dflt_load),
        .cmd_valid_o              (cmd_vo),
        .cmd_data_o               (cmd_do),
        .cmd_drop_o               (cmd_drop)
    );

    task automatic final_report;
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic cmd_check(input logic [8:0] d, input bit early);
        host.send_cmd(d, early);
        `CHK(cmd_vo, ~early)
        `CHK(cmd_drop, early)
        if (!early) `CHK(cmd_do, d)
    endtask : cmd_check

    task automatic wait_ready(input int unsigned lo, input int unsigned hi);
        int unsigned cnt;
        cnt = 0;
        while (ready !== 1'b1 && cnt < hi + 20) begin
            @(negedge clk);
            cnt++;
        end
        `CHK(cnt >= lo && cnt <= hi, 1'b1)
        `CHK(dflt_load, 1'b1)
        `CHK(blank, 1'b0)
        @(negedge clk);
        `CHK(dflt_load, 1'b0)
    endtask : wait_ready

    task automatic check_settings(input logic [7:0] base);
        logic [63:0] exp;
        for (int k = 0; k < 8; k++) exp[8*k+:8] = base + 8'h11 * k[7:0];
        `CHK(settings, exp)
        `CHK(id, exp[23:0])
        `CHK(common_voltage_setting, exp[31:24])
    endtask : check_settings

    task automatic t_power_on;
        cmd_check(9'h12c, 1'b1);
        // One falling edge already spent in the early command
        wait_ready(RT_IN - 2, RT_IN - 1);
        check_settings(8'h30);
        `CHK(rd_cnt, rsq_pkg::NVM_WORDS)
        cmd_check(9'h0e1, 1'b0);
    endtask : t_power_on

    task automatic t_glitch;
        sleep_in = 1'b0;
        rd_cnt   = 0;
        host.drive_pin(1'b0, REJ - 1);
        host.drive_pin(1'b1, REJ + 4);
        `CHK(blank, 1'b0)
        `CHK(ready, 1'b1)
        `CHK(rd_cnt, 0)
    endtask : t_glitch

    task automatic t_awake;
        nvm_base = 8'hc4;
        host.drive_pin(1'b0, REJ + 2);
        `CHK(blank, 1'b1)
        `CHK(blank_seq, 1'b1)
        `CHK(ready, 1'b0)
        rd_cnt = 0;
        // A short high spike inside the held reset must not release it
        host.drive_pin(1'b1, REJ - 2);
        host.drive_pin(1'b0, REJ + 2);
        `CHK(rd_cnt, 0)
        `CHK(blank, 1'b1)
        host.drive_pin(1'b1, 0);
        cmd_check(9'h055, 1'b1);
        // Bound counts from the pin edge; one falling edge already spent
        wait_ready(RT_OUT - 2, RT_OUT - 1);
        `CHK(blank_seq, 1'b0)
        check_settings(8'hc4);
        `CHK(rd_cnt, rsq_pkg::NVM_WORDS)
        cmd_check(9'h1c3, 1'b0);
    endtask : t_awake

    task automatic t_sleep;
        sleep_in = 1'b1;
        nvm_base = 8'h07;
        rd_cnt   = 0;
        // Held past the sure-reset width to reach the long-pulse check
        host.drive_pin(1'b0, rsq_pkg::RESET_SURE_CYC + 2);
        `CHK(blank, 1'b1)
        `CHK(blank_seq, 1'b0)
        `CHK(rd_cnt, 0)
        host.drive_pin(1'b1, 0);
        wait_ready(RT_IN - 2, RT_IN);
        check_settings(8'h07);
        `CHK(rd_cnt, rsq_pkg::NVM_WORDS)
    endtask : t_sleep

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_power_on;
        t_glitch;
        t_awake;
        t_sleep;
        final_report;
    end

    // About 2000 cycles are expected; allow a wide margin
    initial begin
        #(5000 * 8);
        fails++;
        final_report;
    end
endmodule : testbench
